// ==== hdl/acd_pkg.sv ====
// acd_pkg: constants shared by the accelerometer serial command decoder
// assumes a 10 MHz system clock; times are converted to cycle counts here
package acd_pkg;
  // command field positions
  localparam int CMD_B15 = 15;
  localparam int CMD_B14 = 14;
  localparam int CMD_ACC = 13;
  localparam int ADDR_HI = 12;
  localparam int ADDR_LO = 8;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  // register addresses and control bit positions
  localparam logic [4:0] ADDR_DEV_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_DEV_STATUS = 5'h01;
  localparam int CTL_CLEAR_ERR = 7;
  localparam int CTL_HPF = 2;
  localparam int CTL_SELFTEST_HI = 1;
  localparam int CTL_SELFTEST_LO = 0;
  localparam logic [7:0] CTL_READ_MASK = 8'h07;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int STAT_RESET_FLAG = 0;
  localparam int STAT_TRANSIENT_LO = 1;
  localparam int STAT_TRANSIENT_HI = 7;
  localparam logic [7:0] STAT_RESET = 8'h00;
  // response patterns
  localparam logic [15:0] RSP_REQ_ERR = 16'h8000;
  localparam logic [15:0] RSP_SPI_ERR = 16'hc000;
  localparam logic [15:0] RSP_WRITE_BASE = 16'h4000;
  localparam logic [15:0] RSP_READ_BASE = 16'h8000;
  localparam logic [15:0] RSP_TEST_BASE = 16'hc000;
  localparam logic [15:0] RSP_NO_DATA = 16'h0c10;
  localparam logic [15:0] RSP_HW_ERR = 16'h0c20;
  localparam logic [15:0] RSP_OSC_ERR = 16'hffff;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int INIT_PH1_US = 3000;
  localparam int INIT_HPF_US = 200000;
  localparam int INIT_PH1_CYC = INIT_PH1_US * (CLK_HZ / 1_000_000);
  localparam int INIT_HPF_CYC = INIT_HPF_US * (CLK_HZ / 1_000_000);
  localparam int INIT_PH1_SPLIT_DIV = 2;
  localparam int CNT_W = 22;
endpackage : acd_pkg

// ==== hdl/acd_sync.sv ====
// acd_sync: two-flop synchroniser for a vector of asynchronous pins
// assumes pins are quasi-static relative to the 10 MHz system clock
`timescale 1ns/1ps
`default_nettype none
module acd_sync #(
  parameter int W = 3
) (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_in, // sync reset, high
  input wire logic [W-1:0] async_in, // raw pins
  output logic [W-1:0] sync_out // synchronised
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  // two stages, first read only by second
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule : acd_sync
`default_nettype wire

// ==== hdl/acd_decoder.sv ====
// acd_decoder: serial slave command decoder with one-deep response queue
// assumes link pins are asynchronous and slow against the 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module acd_decoder
  import acd_pkg::*;
(
  input wire logic clk_sys_in, // 10 MHz clock
  input wire logic rst_in, // power-on or undervoltage reset
  input wire logic soft_reset_in, // controller reset request
  input wire logic sclk_in, // serial clock pin
  input wire logic cs_n_in, // chip select pin, low active
  input wire logic mosi_in, // serial data in
  input wire logic osc_fault_in, // critical oscillator fault level
  input wire logic [6:0] fault_cond_in, // transient fault conditions
  input wire logic [7:0] accel_word_in, // acceleration data byte, low part
  output logic miso_out, // serial data out
  output logic miso_oe_out, // data out enable
  output logic [7:0] device_control_reg_out, // control register
  output logic [7:0] device_status_reg_out, // status register
  output logic init_busy_out, // initialization in progress
  output logic spi_error_out // last frame had a serial error
);
  typedef enum logic [1:0] {ST_PH1 = 2'b00, ST_PH2 = 2'b01, ST_RUN = 2'b11} acd_init_t;

  logic [2:0] pins_s;
  logic sclk_s, cs_n_s, mosi_s;
  // select enters inverted so cleared sync flops read as deselected
  acd_sync #(.W(3)) acd_sync_i (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({sclk_in, ~cs_n_in, mosi_in}),
    .sync_out(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign cs_n_s = ~pins_s[1];
  assign mosi_s = pins_s[0];

  // state registers
  acd_init_t init_r, init_nxt;
  logic [CNT_W-1:0] icnt_r, icnt_nxt;
  logic first_acc_r, first_acc_nxt;
  logic sclk_d_r, sclk_d_nxt, cs_d_r, cs_d_nxt;
  logic [15:0] sh_in_r, sh_in_nxt, sh_out_r, sh_out_nxt, rsp_r, rsp_nxt;
  logic [4:0] edges_r, edges_nxt;
  logic bad_r, bad_nxt;
  logic [7:0] ctl_r, ctl_nxt, stat_r, stat_nxt;
  logic miso_r, miso_nxt, oe_r, oe_nxt, serr_r, serr_nxt;
  logic busy_r, busy_nxt;

  logic rise, fall, sel_start, sel_end, any_rst;
  logic [4:0] addr;
  logic [15:0] cmd;
  logic [CNT_W-1:0] init_len;

  // command classification
  function automatic logic [1:0] op_of(input logic [15:0] c);
    op_of = {c[CMD_B15], c[CMD_B14]};
  endfunction : op_of

  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;
  assign sel_start = ~cs_n_s & cs_d_r;
  assign sel_end = cs_n_s & ~cs_d_r;
  assign any_rst = rst_in | soft_reset_in;
  assign init_len = ctl_r[CTL_HPF] ? CNT_W'(INIT_PH1_CYC + INIT_HPF_CYC) : CNT_W'(INIT_PH1_CYC);
  assign cmd = {sh_in_r[14:0], mosi_s};
  // register address of the finished frame
  assign addr = sh_in_r[ADDR_HI:ADDR_LO];

  // next-state logic
  always_comb begin
    init_nxt = init_r;
    icnt_nxt = icnt_r;
    first_acc_nxt = first_acc_r;
    sclk_d_nxt = sclk_s;
    cs_d_nxt = cs_n_s;
    sh_in_nxt = sh_in_r;
    sh_out_nxt = sh_out_r;
    rsp_nxt = rsp_r;
    edges_nxt = edges_r;
    bad_nxt = bad_r;
    ctl_nxt = ctl_r;
    stat_nxt = stat_r;
    miso_nxt = miso_r;
    oe_nxt = oe_r;
    serr_nxt = serr_r;
    ctl_nxt[CTL_CLEAR_ERR] = 1'b0;
    unique case (init_r)
      ST_PH1: begin
        icnt_nxt = icnt_r + 1'b1;
        if (icnt_r >= CNT_W'(INIT_PH1_CYC / INIT_PH1_SPLIT_DIV))
          init_nxt = ST_PH2;
      end
      ST_PH2: begin
        icnt_nxt = icnt_r + 1'b1;
        if (icnt_r >= init_len)
          init_nxt = ST_RUN;
      end
      ST_RUN: icnt_nxt = icnt_r;
      default: init_nxt = ST_PH1;
    endcase
    busy_nxt = (init_nxt != ST_RUN);
    // persisting conditions set again every cycle
    stat_nxt[STAT_TRANSIENT_HI:STAT_TRANSIENT_LO] = stat_r[STAT_TRANSIENT_HI:STAT_TRANSIENT_LO] | fault_cond_in;
    // phase one ignores the link entirely
    if (init_r == ST_PH1) begin
      oe_nxt = 1'b0;
    end else begin
      // clock must be low at select edges
      if (sel_start) begin
        edges_nxt = 5'h00;
        bad_nxt = sclk_s;
        oe_nxt = 1'b1;
        sh_out_nxt = rsp_r;
        miso_nxt = rsp_r[FRAME_BITS-1];
      end
      if (!cs_n_s && !sel_start) begin
        // sample on rise, shift on fall, msb first
        if (rise) begin
          sh_in_nxt = cmd;
          if (edges_r != 5'h1f)
            edges_nxt = edges_r + 5'h01;
        end
        if (fall) begin
          sh_out_nxt = {sh_out_r[14:0], 1'b0};
          miso_nxt = sh_out_r[14];
        end
      end
      if (sel_end) begin
        oe_nxt = 1'b0;
        serr_nxt = bad_r | sclk_s | (edges_r != FRAME_EDGES);
        // build answer for the next frame
        if (serr_nxt) begin
          rsp_nxt = RSP_SPI_ERR;
        end else if (osc_fault_in) begin
          rsp_nxt = RSP_OSC_ERR;
        end else if (sh_in_r[CMD_ACC]) begin
          if (init_r != ST_RUN || first_acc_r) begin
            rsp_nxt = RSP_NO_DATA;
            if (init_r == ST_RUN)
              first_acc_nxt = 1'b0;
          end else if (|stat_r[STAT_TRANSIENT_HI:STAT_TRANSIENT_LO]) begin
            rsp_nxt = RSP_HW_ERR;
          end else begin
            rsp_nxt = {8'h04, accel_word_in};
          end
        end else begin
          // non-acceleration: only request error possible here
          unique case (op_of(sh_in_r))
            2'b01: begin
              if (addr == ADDR_DEV_CONTROL) begin
                ctl_nxt = sh_in_r[7:0];
                // clear reset flag only after init
                if (sh_in_r[CTL_CLEAR_ERR]) begin
                  stat_nxt[STAT_TRANSIENT_HI:STAT_TRANSIENT_LO] = fault_cond_in;
                  if (init_r == ST_RUN)
                    stat_nxt[STAT_RESET_FLAG] = 1'b0;
                end
                // readable control bits in low byte
                rsp_nxt = RSP_WRITE_BASE | {8'h00, sh_in_r[7:0] & CTL_READ_MASK};
              end else begin
                rsp_nxt = RSP_REQ_ERR;
              end
            end
            2'b10: begin
              if (addr == ADDR_DEV_CONTROL)
                rsp_nxt = RSP_READ_BASE | {8'h00, ctl_r & CTL_READ_MASK};
              else if (addr == ADDR_DEV_STATUS)
                rsp_nxt = RSP_READ_BASE | {8'h00, stat_r};
              else
                rsp_nxt = RSP_READ_BASE;
            end
            2'b11: rsp_nxt = RSP_TEST_BASE | {8'h00, stat_r};
            2'b00: rsp_nxt = RSP_REQ_ERR;
          endcase
        end
      end
    end
  end

  // state registers; either reset source restarts init
  always_ff @(posedge clk_sys_in) begin
    if (any_rst) begin
      init_r <= ST_PH1;
      icnt_r <= '0;
      first_acc_r <= 1'b1;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      sh_in_r <= 16'h0000;
      sh_out_r <= 16'h0000;
      // first frame after reset answers request error
      rsp_r <= RSP_REQ_ERR;
      edges_r <= 5'h00;
      bad_r <= 1'b0;
      ctl_r <= CTL_RESET;
      stat_r <= STAT_RESET | (8'h01 << STAT_RESET_FLAG);
      miso_r <= 1'b0;
      oe_r <= 1'b0;
      serr_r <= 1'b0;
      busy_r <= 1'b1;
    end else begin
      init_r <= init_nxt;
      icnt_r <= icnt_nxt;
      first_acc_r <= first_acc_nxt;
      sclk_d_r <= sclk_d_nxt;
      cs_d_r <= cs_d_nxt;
      sh_in_r <= sh_in_nxt;
      sh_out_r <= sh_out_nxt;
      rsp_r <= rsp_nxt;
      edges_r <= edges_nxt;
      bad_r <= bad_nxt;
      ctl_r <= ctl_nxt;
      stat_r <= stat_nxt;
      miso_r <= miso_nxt;
      oe_r <= oe_nxt;
      serr_r <= serr_nxt;
      busy_r <= busy_nxt;
    end
  end

  // outputs straight from flops
  assign miso_out = miso_r;
  assign miso_oe_out = oe_r;
  assign device_control_reg_out = ctl_r;
  assign device_status_reg_out = stat_r;
  assign init_busy_out = busy_r;
  assign spi_error_out = serr_r;

  chk_ph1_silent: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (init_r == ST_PH1) |=> !oe_r) else $error("output driven in init phase one");
  chk_edge_count: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (sel_end && init_r != ST_PH1 && !bad_r && !sclk_s && edges_r != FRAME_EDGES) |=> serr_r)
    else $error("wrong edge count not flagged");
  chk_spi_frame: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (sel_end && init_r != ST_PH1 && bad_r) |=> (rsp_r == RSP_SPI_ERR)) else $error("serial error frame wrong");
  chk_noop_err: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (sel_end && init_r != ST_PH1 && !osc_fault_in && !bad_r && !sclk_s && edges_r == FRAME_EDGES
     && sh_in_r[15:13] == 3'b000) |=> (rsp_r == RSP_REQ_ERR)) else $error("noop not request error");
  // acceleration during init gives no data
  chk_init_nodata: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (sel_end && init_r == ST_PH2 && !osc_fault_in && !bad_r && !sclk_s && edges_r == FRAME_EDGES
     && sh_in_r[CMD_ACC]) |=> (rsp_r == RSP_NO_DATA)) else $error("init acceleration not no data");
  chk_rstflag_hold: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (init_r != ST_RUN && stat_r[STAT_RESET_FLAG]) |=> stat_r[STAT_RESET_FLAG])
    else $error("reset flag cleared during init");
  chk_fault_sticky: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    fault_cond_in[0] |=> stat_r[STAT_TRANSIENT_LO]) else $error("persisting fault not set");
  chk_cs_sclk: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (sel_start && sclk_s && init_r != ST_PH1) |=> bad_r) else $error("clock high at select not caught");
  chk_osc_wins: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (sel_end && init_r != ST_PH1 && osc_fault_in && !bad_r && !sclk_s && edges_r == FRAME_EDGES)
    |=> (rsp_r == RSP_OSC_ERR)) else $error("oscillator fault not reported");
  // first acceleration after init gives no data
  chk_first_nodata: assert property (@(posedge clk_sys_in) disable iff (any_rst)
    (sel_end && init_r == ST_RUN && first_acc_r && !osc_fault_in && !bad_r && !sclk_s
     && edges_r == FRAME_EDGES && sh_in_r[CMD_ACC]) |=> (rsp_r == RSP_NO_DATA && !first_acc_r))
    else $error("first acceleration after init not no data");
endmodule : acd_decoder
`default_nettype wire

// ==== bench/acd_spi_master.sv ====
// acd_spi_master: behavioural serial master for the decoder link
// assumes the bench clock paces every pin change
`timescale 1ns/1ps
`default_nettype none
module acd_spi_master (
  input wire logic clk_sys_in, // bench clock
  input wire logic miso_in, // device data out
  input wire logic miso_oe_in, // device drive enable
  output logic sclk_out, // serial clock
  output logic cs_n_out, // chip select, low active
  output logic mosi_out // data to device
);
  logic last_r; // last level seen on the data line
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
    last_r = 1'b0;
  end
  // wait some bench clock edges
  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : tick
  // one framed transfer; hi bit 0 or 1 leaves the clock high at select or deselect
  task xfer(input logic [15:0] cmd, input int edges, input logic [1:0] hi, output logic [15:0] rsp);
    rsp = 16'h0000;
    tick(1);
    sclk_out <= hi[0];
    tick(4);
    cs_n_out <= 1'b0;
    tick(4);
    sclk_out <= 1'b0;
    for (int i = 0; i < edges; i++) begin
      mosi_out <= (i < 16) ? cmd[15 - i] : ~mosi_out;
      tick(4);
      // a released line shows the inverse of its last level
      last_r = miso_oe_in ? miso_in : ~last_r;
      if (i < 16) rsp[15 - i] = last_r;
      sclk_out <= 1'b1;
      tick(4);
      sclk_out <= 1'b0;
    end
    tick(4);
    // clock and select move together so no extra edge is counted
    sclk_out <= hi[1];
    cs_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    tick(4);
    sclk_out <= 1'b0;
    tick(8);
  endtask : xfer
endmodule : acd_spi_master
`default_nettype wire

// ==== bench/acd_decoder_tb.sv ====
// acd_decoder_tb: self-checking bench for the serial command decoder
// assumes the fixed init timing of the decoder and the master model
`timescale 1ns/1ps
`default_nettype none
module acd_decoder_tb;
  import acd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic soft_reset = 1'b0;
  logic osc_fault = 1'b0;
  logic [6:0] fault_cond = 7'h00;
  logic [7:0] accel_word = 8'h5a;
  logic sclk, cs_n, mosi, miso, miso_oe, init_busy, spi_error;
  logic [7:0] ctl, stat;
  logic [15:0] rsp;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  int oe_cnt = 0;
  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;
  acd_decoder acd_decoder_i (
    .clk_sys_in(clk_sys), .rst_in(rst), .soft_reset_in(soft_reset), .sclk_in(sclk),
    .cs_n_in(cs_n), .mosi_in(mosi), .osc_fault_in(osc_fault), .fault_cond_in(fault_cond),
    .accel_word_in(accel_word), .miso_out(miso), .miso_oe_out(miso_oe),
    .device_control_reg_out(ctl), .device_status_reg_out(stat),
    .init_busy_out(init_busy), .spi_error_out(spi_error)
  );
  acd_spi_master acd_spi_master_i (
    .clk_sys_in(clk_sys), .miso_in(miso), .miso_oe_in(miso_oe),
    .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi)
  );
  // cycle ceiling and drive-enable count
  always @(posedge clk_sys) begin
    cycles++;
    if (miso_oe === 1'b1) oe_cnt++;
    if (cycles == 60000) begin
      error_cnt++;
      end_sim();
    end
  end
  // compare one value
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // send a command and compare the answer to the previous one
  task xf(input logic [15:0] cmd, input logic [15:0] exp);
    acd_spi_master_i.xfer(cmd, 16, 2'b00, rsp);
    check("response", rsp, exp);
  endtask : xf
  // report and stop
  task end_sim();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    int n;
    repeat (16) @(posedge clk_sys);
    check("control", {8'h00, ctl}, {8'h00, CTL_RESET});
    check("init busy", {15'h0000, init_busy}, 16'h0001);
    rst <= 1'b0;
    @(posedge clk_sys);
    n = oe_cnt;
    acd_spi_master_i.xfer(16'hc000, 16, 2'b00, rsp);
    check("phase one drive", 16'(oe_cnt - n), 16'h0000);
    check("status", {8'h00, stat}, 16'h0001);
    repeat (15000) @(posedge clk_sys);
    n = oe_cnt;
    xf(16'h2000, RSP_REQ_ERR);
    // select stays low for 136 bench clocks per frame
    check("drive enable", 16'(oe_cnt - n), 16'h0088);
    xf(16'h4083, RSP_NO_DATA);
    check("control", {8'h00, ctl}, 16'h0003);
    xf(16'h80ff, RSP_WRITE_BASE | 16'h0003);
    xf(16'h4105, RSP_READ_BASE | 16'h0003);
    check("status", {8'h00, stat}, 16'h0001);
    xf(16'h0000, RSP_REQ_ERR);
    check("control", {8'h00, ctl}, 16'h0003);
    xf(16'hc000, RSP_REQ_ERR);
    for (n = 0; n < 20000 && init_busy !== 1'b0; n++) @(posedge clk_sys);
    check("init busy", {15'h0000, init_busy}, 16'h0000);
    xf(16'h2000, RSP_TEST_BASE | 16'h0001);
    xf(16'h2000, RSP_NO_DATA);
    xf(16'h4083, {8'h04, accel_word});
    check("status", {8'h00, stat}, 16'h0000);
    fault_cond <= 7'h01;
    xf(16'h2000, RSP_WRITE_BASE | 16'h0003);
    xf(16'hc000, RSP_HW_ERR);
    xf(16'h2000, RSP_TEST_BASE | 16'h0002);
    osc_fault <= 1'b1;
    xf(16'h0000, RSP_HW_ERR);
    osc_fault <= 1'b0;
    fault_cond <= 7'h00;
    xf(16'h4083, RSP_OSC_ERR);
    check("status", {8'h00, stat}, 16'h0000);
    fault_cond <= 7'h04;
    xf(16'h4083, RSP_WRITE_BASE | 16'h0003);
    check("status", {8'h00, stat}, 16'h0008);
    fault_cond <= 7'h00;
    // framing faults: short, long, clock high at select, clock high at deselect
    for (int k = 0; k < 4; k++) begin
      acd_spi_master_i.xfer({2'b00, k[0], 13'h0000}, (k == 0) ? 15 : (k == 1) ? 17 : 16,
                            (k < 2) ? 2'b00 : 2'(k - 1), rsp);
      check("serial error", {15'h0000, spi_error}, 16'h0001);
      xf(16'h0000, RSP_SPI_ERR);
      check("serial error", {15'h0000, spi_error}, 16'h0000);
    end
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("init busy", {15'h0000, init_busy}, 16'h0001);
    check("status", {8'h00, stat}, 16'h0001);
    check("control", {8'h00, ctl}, {8'h00, CTL_RESET});
    end_sim();
  end
endmodule : acd_decoder_tb
`default_nettype wire
